// ---- shared/wdt_cfg_pkg.sv ----
// package: constants and carrier types for the watchdog configuration decoder
package wdt_cfg_pkg;
    // apb register map (byte addresses)
    localparam logic [11:0] OFF_CONFIG = 12'h000;
    localparam logic [11:0] OFF_CONTROL = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_MASK = 12'h00c;
    localparam logic [11:0] OFF_CLEAR = 12'h010;
    localparam logic [11:0] OFF_STATE = 12'h014;
    // configuration word field positions
    localparam int HW_EN_BIT = 15;
    localparam int SLEEP_PS_LSB = 10;
    localparam int WIN_LSB = 8;
    localparam int WIN_DIS_BIT = 7;
    localparam int CLK_SEL_LSB = 5;
    localparam int RUN_PS_LSB = 0;
    // unprogrammed word and upper unimplemented byte
    localparam logic [23:0] CONFIG_ERASED = 24'hffffff;
    localparam logic [7:0] UPPER_ONES = 8'hff;
    // control register software on bit; key written to the clear register
    localparam int SW_ON_BIT = 15;
    localparam logic [31:0] CLEAR_KEY = 32'h00005743;
    // status / mask bits
    localparam int EVT_TIMEOUT = 0;
    localparam int EVT_EARLY = 1;
    localparam int EVT_BAD_CFG = 2;
    localparam int EVT_N = 3;
    // clock select codes
    localparam logic [1:0] CLK_LOW_POWER_RC_CLOCK = 2'h3;
    localparam logic [1:0] CLK_FAST = 2'h2;
    localparam logic [1:0] CLK_PERIPH = 2'h1;
    localparam logic [1:0] CLK_RESERVED = 2'h0;
    // longest timeout exponent; larger period codes saturate here
    localparam logic [4:0] MAX_EXPONENT = 5'h1e;
    // reset pulse length
    localparam int RESET_PULSE_NS = 16;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + 3) / 4;

    typedef enum logic [1:0] {
        SRC_LOW_POWER,
        SRC_FAST_RC,
        SRC_PERIPH
    } clk_src_type;

    typedef struct packed {
        logic hw_watchdog_enable;
        logic [4:0] sleep_period_select;
        logic [1:0] window_size_select;
        logic window_disable;
        logic [1:0] watchdog_clock_select;
        logic [4:0] run_period_select;
    } cfg_type;

    typedef struct packed {
        logic low_power_rc_clock;
        logic fast_rc_clock;
        logic periph_clock;
    } tick_type;
endpackage

// ---- logic/wdt_cfg_decode.sv ----
// watchdog driven by a program-once configuration word, with apb access
// =====================================================================
// Contract
// [RQ1] hardware bit forces watchdog on, else software bit
// [RQ2] sleep timeout divides by two to code+1; codes 30 and 31 both saturate at two to 30 here
// [RQ3] run timeout uses separate run field
// [RQ4] window size 25/37.5/50/75 percent of period
// [RQ5] window disable bit selects non-window mode
// [RQ6] select 11 uses low-power rc; 00 reserved
// [RQ7] select 10 fast rc only windowed, awake, external
// [RQ8] select 01 peripheral clock when awake and external
// [RQ9] fields program once, read back, erased ones
// [RQ10] upper byte always reads ones
// [RQ11] reset on timeout or early windowed clear
// [RQ12] word captured at power-on, held until reset
`timescale 1ns/1ps
`default_nettype none
module wdt_cfg_decode (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // nonvolatile storage and program-once port
    input wire logic [23:0] i_nv_word,
    input wire logic i_nv_program,
    input wire logic [23:0] i_nv_program_data,
    // device state
    input wire logic i_sleep,
    input wire logic i_sysclk_internal,
    input wire wdt_cfg_pkg::tick_type i_tick,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // results
    output logic o_device_reset,
    output logic o_irq,
    output logic [23:0] o_nv_word
);
    // =================================================================
    // configuration capture
    logic [23:0] cfg_word_reg;
    logic cfg_loaded_reg;
    wdt_cfg_pkg::cfg_type cfg;
    assign cfg = wdt_cfg_pkg::cfg_type'(cfg_word_reg[15:0]);

    // word loads once after reset release, then holds until the next reset
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_word_reg <= wdt_cfg_pkg::CONFIG_ERASED; // RQ9
            cfg_loaded_reg <= 1'b0;
        end else if (!cfg_loaded_reg) begin
            cfg_word_reg <= {wdt_cfg_pkg::UPPER_ONES, i_nv_word[15:0]}; // RQ12
            cfg_loaded_reg <= 1'b1;
        end
    end

    // storage image: programming only clears bits, the upper byte stays set
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_nv_word <= wdt_cfg_pkg::CONFIG_ERASED;
        end else if (!cfg_loaded_reg) begin
            o_nv_word <= {wdt_cfg_pkg::UPPER_ONES, i_nv_word[15:0]};
        end else if (i_nv_program) begin
            o_nv_word <= {wdt_cfg_pkg::UPPER_ONES, o_nv_word[15:0] & i_nv_program_data[15:0]}; // RQ9 RQ10
        end
    end

    // =================================================================
    // apb decode
    logic setup;
    logic acc_wr;
    logic clear_hit;
    // reads are served from the setup cycle, so only writes need an access decode
    assign setup = psel && !penable;
    assign acc_wr = psel && penable && pwrite;
    assign clear_hit = acc_wr && paddr == wdt_cfg_pkg::OFF_CLEAR && pwdata == wdt_cfg_pkg::CLEAR_KEY;

    logic sw_on_reg;
    logic [wdt_cfg_pkg::EVT_N-1:0] status_reg;
    logic [wdt_cfg_pkg::EVT_N-1:0] mask_reg;

    // software on bit only matters when the hardware bit is clear
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sw_on_reg <= 1'b0;
        end else if (acc_wr && paddr == wdt_cfg_pkg::OFF_CONTROL) begin
            sw_on_reg <= pwdata[wdt_cfg_pkg::SW_ON_BIT];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mask_reg <= '0;
        end else if (acc_wr && paddr == wdt_cfg_pkg::OFF_MASK) begin
            mask_reg <= pwdata[wdt_cfg_pkg::EVT_N-1:0];
        end
    end

    // =================================================================
    // clock source and period selection
    logic wdt_on;
    logic [4:0] period_code;
    wdt_cfg_pkg::clk_src_type src;
    logic tick;
    assign wdt_on = cfg.hw_watchdog_enable || sw_on_reg; // RQ1
    assign period_code = i_sleep ? cfg.sleep_period_select : cfg.run_period_select; // RQ2 RQ3

    // fallback is the low-power oscillator whenever a condition fails
    always_comb begin
        src = wdt_cfg_pkg::SRC_LOW_POWER; // RQ6
        case (cfg.watchdog_clock_select)
            wdt_cfg_pkg::CLK_FAST: begin
                if (!cfg.window_disable && !i_sysclk_internal && !i_sleep) begin
                    src = wdt_cfg_pkg::SRC_FAST_RC; // RQ7
                end
            end
            wdt_cfg_pkg::CLK_PERIPH: begin
                if (!i_sysclk_internal && !i_sleep) begin
                    src = wdt_cfg_pkg::SRC_PERIPH; // RQ8
                end
            end
            default: src = wdt_cfg_pkg::SRC_LOW_POWER;
        endcase
    end

    always_comb begin
        case (src)
            wdt_cfg_pkg::SRC_FAST_RC: tick = i_tick.fast_rc_clock;
            wdt_cfg_pkg::SRC_PERIPH: tick = i_tick.periph_clock;
            default: tick = i_tick.low_power_rc_clock;
        endcase
    end

    // =================================================================
    // counter, window and timeout
    logic [30:0] count_reg;
    logic [30:0] limit;
    logic [30:0] period_len;
    logic [30:0] win_open;
    logic [4:0] exponent;
    logic timeout;
    logic early;
    // codes past the widest period saturate; a plain code+1 would wrap the
    // five-bit exponent and turn the longest setting into the shortest
    assign exponent = (period_code >= wdt_cfg_pkg::MAX_EXPONENT) ?
        wdt_cfg_pkg::MAX_EXPONENT : period_code + 5'h1; // RQ2 RQ3
    assign limit = 31'((32'h1 << exponent) - 32'h1); // RQ2 RQ3
    assign period_len = limit + 31'h1;

    // window opens once (1 - fraction) of the period has passed; shifting the
    // period rather than the limit keeps the split exact for every code above 1
    always_comb begin
        case (cfg.window_size_select)
            2'h3: win_open = 31'((period_len >> 1) + (period_len >> 2)); // RQ4 25 percent window
            2'h2: win_open = 31'((period_len >> 1) + (period_len >> 3)); // RQ4 37.5 percent
            2'h1: win_open = period_len >> 1; // RQ4 50 percent
            default: win_open = period_len >> 2; // RQ4 75 percent
        endcase
    end

    // compare with >= so a switch to a shorter period cannot skip the timeout
    assign timeout = wdt_on && tick && count_reg >= limit; // RQ11
    assign early = wdt_on && clear_hit && !cfg.window_disable && count_reg < win_open; // RQ5 RQ11

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_reg <= '0;
        end else if (!wdt_on || clear_hit || timeout) begin
            count_reg <= '0;
        end else if (tick) begin
            count_reg <= count_reg + 31'h1;
        end
    end

    // reset pulse stretched so the reset tree sees it cleanly
    logic [3:0] rst_cnt_reg;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_cnt_reg <= '0;
            o_device_reset <= 1'b0;
        end else if (timeout || early) begin
            rst_cnt_reg <= 4'(wdt_cfg_pkg::RESET_PULSE_CYC - 1);
            o_device_reset <= 1'b1; // RQ11
        end else if (rst_cnt_reg != 4'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 4'h1;
        end else begin
            o_device_reset <= 1'b0;
        end
    end

    // =================================================================
    // sticky status; a new event beats a write-one clear
    logic [wdt_cfg_pkg::EVT_N-1:0] evt;
    assign evt[wdt_cfg_pkg::EVT_TIMEOUT] = timeout;
    assign evt[wdt_cfg_pkg::EVT_EARLY] = early;
    assign evt[wdt_cfg_pkg::EVT_BAD_CFG] = cfg_loaded_reg && cfg.watchdog_clock_select == wdt_cfg_pkg::CLK_RESERVED; // RQ6

    genvar gi;
    generate
        for (gi = 0; gi < wdt_cfg_pkg::EVT_N; gi++) begin : g_status
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    status_reg[gi] <= 1'b0;
                end else if (evt[gi]) begin
                    status_reg[gi] <= 1'b1;
                end else if (acc_wr && paddr == wdt_cfg_pkg::OFF_STATUS && pwdata[gi]) begin
                    status_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_reg & mask_reg);
        end
    end

    // =================================================================
    // apb read path: no wait states, data registered in setup
    logic [31:0] rd_next;
    logic bad_next;
    always_comb begin
        rd_next = '0;
        bad_next = 1'b0;
        case (paddr)
            wdt_cfg_pkg::OFF_CONFIG: rd_next = {8'h00, cfg_word_reg}; // RQ9 RQ10
            wdt_cfg_pkg::OFF_CONTROL: rd_next = 32'(sw_on_reg) << wdt_cfg_pkg::SW_ON_BIT;
            wdt_cfg_pkg::OFF_STATUS: rd_next = 32'(status_reg);
            wdt_cfg_pkg::OFF_MASK: rd_next = 32'(mask_reg);
            wdt_cfg_pkg::OFF_CLEAR: rd_next = '0;
            wdt_cfg_pkg::OFF_STATE: rd_next = {src, wdt_on, 29'(count_reg)};
            default: bad_next = 1'b1;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && bad_next;
            if (setup && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // =================================================================
    // checks
    hw_enable_on_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        cfg.hw_watchdog_enable |-> wdt_on) else $error("hardware enable did not force watchdog"); // RQ1
    sleep_limit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ2
        i_sleep && cfg.sleep_period_select < 5'h1d
        |-> limit == 31'((32'h1 << (cfg.sleep_period_select + 5'h1)) - 32'h1))
        else $error("sleep limit wrong");
    run_limit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ3
        !i_sleep && cfg.run_period_select < 5'h1d
        |-> limit == 31'((32'h1 << (cfg.run_period_select + 5'h1)) - 32'h1))
        else $error("run limit wrong");
    top_period_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ2 RQ3
        period_code == 5'h1f |-> limit == 31'h3fffffff)
        else $error("longest period wrong");
    window_quarter_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ4
        cfg.window_size_select == 2'h0 |-> win_open == period_len >> 2)
        else $error("75 percent window wrong");
    window_half_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ4
        cfg.window_size_select == 2'h1 |-> win_open == period_len >> 1)
        else $error("50 percent window wrong");
    window_mid_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ4
        cfg.window_size_select == 2'h2 && limit > 31'h6
        |-> win_open == period_len - (period_len >> 2) - (period_len >> 3)) else $error("37.5 percent window wrong");
    window_narrow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ4
        cfg.window_size_select == 2'h3 && limit > 31'h6
        |-> win_open == period_len - (period_len >> 2)) else $error("25 percent window wrong");
    no_window_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        cfg.window_disable |-> !early) else $error("early reset in non-window mode"); // RQ5
    low_power_rc_clock_select_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        cfg.watchdog_clock_select == wdt_cfg_pkg::CLK_LOW_POWER_RC_CLOCK |-> src == wdt_cfg_pkg::SRC_LOW_POWER)
        else $error("low-power clock not chosen"); // RQ6
    fast_rc_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        src == wdt_cfg_pkg::SRC_FAST_RC |-> !cfg.window_disable && !i_sleep && !i_sysclk_internal)
        else $error("fast rc chosen illegally"); // RQ7
    periph_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        cfg.watchdog_clock_select == wdt_cfg_pkg::CLK_PERIPH && !i_sleep && !i_sysclk_internal
        |-> src == wdt_cfg_pkg::SRC_PERIPH) else $error("peripheral clock not chosen"); // RQ8
    upper_ones_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        cfg_word_reg[23:16] == wdt_cfg_pkg::UPPER_ONES && o_nv_word[23:16] == wdt_cfg_pkg::UPPER_ONES)
        else $error("upper byte not ones"); // RQ10
    timeout_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        timeout || early |=> o_device_reset [*4]) else $error("reset pulse missing"); // RQ11
    cfg_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        cfg_loaded_reg |=> $stable(cfg_word_reg)) else $error("configuration changed"); // RQ12
    program_once_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        cfg_loaded_reg && $past(cfg_loaded_reg) |-> (o_nv_word & ~$past(o_nv_word)) == 24'h000000)
        else $error("programmed bit returned to one"); // RQ9

    // =================================================================
    // further checks on enable, source fallback, events and the bus
    sw_enable_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ1
        !cfg.hw_watchdog_enable && !sw_on_reg |=> count_reg == 31'h0)
        else $error("counter ran while switched off");
    reserved_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ6
        cfg_loaded_reg && cfg.watchdog_clock_select == wdt_cfg_pkg::CLK_RESERVED
        |=> status_reg[wdt_cfg_pkg::EVT_BAD_CFG] && src == wdt_cfg_pkg::SRC_LOW_POWER)
        else $error("reserved clock select not flagged");
    fast_rc_use_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ7
        cfg.watchdog_clock_select == wdt_cfg_pkg::CLK_FAST && !cfg.window_disable && !i_sleep && !i_sysclk_internal
        |-> src == wdt_cfg_pkg::SRC_FAST_RC) else $error("fast rc not chosen");
    periph_fallback_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ8
        cfg.watchdog_clock_select == wdt_cfg_pkg::CLK_PERIPH && (i_sleep || i_sysclk_internal)
        |-> src == wdt_cfg_pkg::SRC_LOW_POWER) else $error("peripheral clock used without fallback");
    erased_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ9
        !cfg_loaded_reg |-> cfg_word_reg == wdt_cfg_pkg::CONFIG_ERASED)
        else $error("configuration not erased before load");
    timeout_status_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ11
        timeout |=> status_reg[wdt_cfg_pkg::EVT_TIMEOUT] && count_reg == 31'h0)
        else $error("timeout not recorded");
    early_status_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ11
        early |=> status_reg[wdt_cfg_pkg::EVT_EARLY] && count_reg == 31'h0)
        else $error("early clear not recorded");
    count_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ11
        clear_hit |=> count_reg == 31'h0)
        else $error("clear key did not restart counter");
    pulse_end_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ11
        o_device_reset && rst_cnt_reg == 4'h0 && !timeout && !early |=> !o_device_reset)
        else $error("reset pulse too long");
    cfg_load_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RQ12
        !cfg_loaded_reg |=> cfg_loaded_reg && cfg_word_reg == o_nv_word)
        else $error("configuration not loaded from storage");
    irq_level_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (|(status_reg & mask_reg)) |=> o_irq)
        else $error("interrupt missing");
    irq_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !(|(status_reg & mask_reg)) |=> !o_irq)
        else $error("interrupt without cause");
    apb_ready_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        1'b1 |=> pready == $past(setup))
        else $error("bus ready not one cycle after setup");
    apb_error_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        pslverr |-> pready)
        else $error("bus error without ready");
endmodule // wdt_cfg_decode
`default_nettype wire

// ---- tb/watchdog_config_word_decode_tb.sv ----
// self-checking testbench for the watchdog configuration decoder
`timescale 1ns/1ps
`default_nettype none
module watchdog_config_word_decode_tb;
// =====================================================================
// signals
logic i_core_clk = 1'b0;
logic i_rst_b = 1'b0;
logic [23:0] i_nv_word = 24'hffffff;
logic i_nv_program = 1'b0;
logic [23:0] i_nv_program_data = 24'h000000;
logic i_sleep = 1'b0;
logic i_sysclk_internal = 1'b0;
wdt_cfg_pkg::tick_type i_tick = 3'h0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata, rd, r0;
logic pready, pslverr, o_device_reset, o_irq, err;
logic [23:0] o_nv_word;
int mismatches = 0;
int tests_run = 0;
int hi_cnt = 0;
int h0;
// =====================================================================
// design under test
wdt_cfg_decode wdt_cfg_decode_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_nv_word(i_nv_word),
    .i_nv_program(i_nv_program), .i_nv_program_data(i_nv_program_data), .i_sleep(i_sleep),
    .i_sysclk_internal(i_sysclk_internal), .i_tick(i_tick), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_device_reset(o_device_reset), .o_irq(o_irq), .o_nv_word(o_nv_word));
// 250 MHz core clock
always #2 i_core_clk = ~i_core_clk;
// count cycles with reset request high, so pulse length is checked
always @(posedge i_core_clk) if (o_device_reset === 1'b1) hi_cnt <= hi_cnt + 1;
// =====================================================================
// shared tasks
task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
        mismatches++;
        $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
endtask
// one apb transfer; waits for ready however long, the watchdog ends a hang
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
        @(posedge i_core_clk);
        n++;
    end while (pready !== 1'b1);
    chk(n, 1, "apb wait states");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
// storage word is captured only at reset release
task rst(input logic [23:0] w);
    i_rst_b <= 1'b0;
    i_nv_word <= w;
    repeat (6) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_core_clk);
endtask
task tick(input logic [2:0] s, input int n);
    repeat (n) begin
        @(posedge i_core_clk);
        i_tick <= s;
        @(posedge i_core_clk);
        i_tick <= 3'h0;
    end
    repeat (3) @(posedge i_core_clk);
endtask
task prog(input logic [23:0] d);
    @(posedge i_core_clk);
    i_nv_program <= 1'b1;
    i_nv_program_data <= d;
    @(posedge i_core_clk);
    i_nv_program <= 1'b0;
    repeat (2) @(posedge i_core_clk);
endtask
// upper byte is junk on purpose: it must never show
function logic [23:0] word(input logic hw, input logic [4:0] sp, input logic [1:0] wn, input logic wd,
    input logic [1:0] cs, input logic [4:0] rp);
    return {8'h5a, hw, sp, wn, wd, cs, rp};
endfunction
// =====================================================================
// scenarios
task t_config;
    rst(24'h5a6b2d);
    apb(1'b1, wdt_cfg_pkg::OFF_CONFIG, 32'h0);
    apb(1'b0, wdt_cfg_pkg::OFF_CONFIG, 32'h0);
    chk(rd, 32'h00ff6b2d, "config read");
    chk(o_nv_word, 24'hff6b2d, "nv image");
    apb(1'b0, 12'h018, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped");
    prog(24'h00f0f0);
    prog(24'h00ffff);
    chk(o_nv_word, 24'hff6020, "program once");
    apb(1'b0, wdt_cfg_pkg::OFF_CONFIG, 32'h0);
    chk(rd, 32'h00ff6b2d, "held to reset");
    rst(24'h5a6020);
    apb(1'b0, wdt_cfg_pkg::OFF_CONFIG, 32'h0);
    chk(rd, 32'h00ff6020, "new at reset");
    $display("test config done");
endtask
task t_enable;
    rst(word(1'b0, 5'h00, 2'h3, 1'b1, 2'h3, 5'h00));
    apb(1'b1, wdt_cfg_pkg::OFF_MASK, 32'h1);
    apb(1'b0, wdt_cfg_pkg::OFF_STATE, 32'h0);
    chk(rd[29], 0, "sw off");
    tick(3'h4, 3);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 0, "off no timeout");
    apb(1'b1, wdt_cfg_pkg::OFF_CONTROL, 32'h8000);
    apb(1'b0, wdt_cfg_pkg::OFF_CONTROL, 32'h0);
    chk(rd, 32'h8000, "control rw");
    h0 = hi_cnt;
    tick(3'h4, 1);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 0, "one tick early");
    tick(3'h4, 1);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 1, "timeout");
    chk(o_irq, 1, "irq");
    chk(hi_cnt - h0, 4, "pulse");
    apb(1'b1, wdt_cfg_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge i_core_clk);
    chk(o_irq, 0, "masked");
    apb(1'b1, wdt_cfg_pkg::OFF_MASK, 32'h1);
    apb(1'b1, wdt_cfg_pkg::OFF_STATUS, 32'h1);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk({rd[0], o_irq}, 0, "w1c");
    rst(word(1'b1, 5'h00, 2'h3, 1'b1, 2'h3, 5'h00));
    apb(1'b0, wdt_cfg_pkg::OFF_STATE, 32'h0);
    chk(rd[29], 1, "hw on");
    $display("test enable done");
endtask
task t_period;
    rst(word(1'b1, 5'h01, 2'h3, 1'b1, 2'h3, 5'h02));
    tick(3'h4, 7);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 0, "run 7");
    tick(3'h4, 1);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 1, "run 8");
    apb(1'b1, wdt_cfg_pkg::OFF_STATUS, 32'h7);
    i_sleep <= 1'b1;
    apb(1'b1, wdt_cfg_pkg::OFF_CLEAR, wdt_cfg_pkg::CLEAR_KEY);
    tick(3'h4, 3);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 0, "sleep 3");
    tick(3'h4, 1);
    apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 1, "sleep 4");
    i_sleep <= 1'b0;
    $display("test period done");
endtask
// window opens at 2, 4, 5, 6 counts of 8 for codes 00..11
task t_window;
    int opn[4];
    opn = '{2, 4, 5, 6};
    for (int k = 0; k < 5; k++) begin
        for (int e = 0; e < 2; e++) begin
            rst(word(1'b1, 5'h1f, k[1:0], k == 4, 2'h3, 5'h02));
            h0 = hi_cnt;
            tick(3'h4, (k == 4) ? 1 : opn[k] - 1 + e);
            apb(1'b1, wdt_cfg_pkg::OFF_CLEAR, wdt_cfg_pkg::CLEAR_KEY);
            repeat (6) @(posedge i_core_clk);
            apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
            chk(rd[1], (k < 4 && e == 0), "early clear");
            chk(hi_cnt - h0, (k < 4 && e == 0) ? 4 : 0, "early reset");
        end
    end
    $display("test window done");
endtask
task t_clksel;
    logic [1:0] x;
    for (int s = 0; s < 4; s++) begin
        for (int wd = 0; wd < 2; wd++) begin
            rst(word(1'b1, 5'h1f, 2'h3, wd[0], s[1:0], 5'h1f));
            for (int c = 0; c < 4; c++) begin
                i_sleep <= c[0];
                i_sysclk_internal <= c[1];
                x = (s == 2 && wd == 0 && c == 0) ? 2'h1 : (s == 1 && c == 0) ? 2'h2 : 2'h0;
                apb(1'b0, wdt_cfg_pkg::OFF_STATE, 32'h0);
                r0 = rd;
                tick((x == 2'h0) ? 3'h4 : (x == 2'h1) ? 3'h2 : 3'h1, 1);
                apb(1'b0, wdt_cfg_pkg::OFF_STATE, 32'h0);
                chk(rd[31:30], x, "source");
                chk(rd[28:0] - r0[28:0], 1, "source ticks");
            end
            apb(1'b0, wdt_cfg_pkg::OFF_STATUS, 32'h0);
            chk(rd[2], s == 0, "reserved select");
        end
    end
    $display("test clock select done");
endtask
// =====================================================================
// verdict, main sequence and watchdog
task final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
initial begin
    t_config;
    t_enable;
    t_period;
    t_window;
    t_clksel;
    final_report;
end
// the full run needs well under a tenth of this span
initial begin
    #200000;
    mismatches++;
    final_report;
end
endmodule // watchdog_config_word_decode_tb
`default_nettype wire
